// file: rtl/plb_logic_block.v
`timescale 1ns/1ps
`include "plb_map.vh"
// Operation
// - each macrocell flip-flop works as D type or T type
// - each flip-flop captures on rising or falling edge of its clock
// - four clocks; the first is always external and synchronous
// - other three clocks come from a pin or a macrocell equation
// - six control terms, each either a sum or a product
// - first two control terms preset and reset, each disablable per macrocell
// - reset leaves every macrocell flip-flop at zero
// - last four control terms are selectable output enables
// - output buffer may instead be always on or always off
// - enabled global tristate pin low tristates every output
// - two feedbacks per macrocell: macrocell logic and pin
// - input pin has buffer off, pin fed back, macrocell still fed back
// - 36 inputs, 16 macrocells, 32 feedback signals
// - five dedicated terms plus any of 32 pool terms, 37 at most
// - one pool term may feed several macrocells at once
module plb_logic_block (
  input wire sysClk,
  input wire sysRst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [35:0] iaIn,
  input wire dedicatedSyncClock,
  input wire flexClockOne,
  input wire flexClockTwo,
  input wire flexClockThree,
  input wire globalTristatePinN,
  input wire [15:0] padIn,
  output wire [15:0] padOut,
  output wire [15:0] padOe,
  output wire [15:0] fbMacro,
  output reg [15:0] fbPin
);
  // configuration storage
  reg [35:0] termTrue [0:117];
  reg [35:0] termComp [0:117];
  reg [8:0] mcCfg [0:15];
  reg [31:0] plaAlloc [0:15];
  reg [5:0] ctMode_reg;
  reg [14:0] clkCfg_reg;
  reg gtsEn_reg;

  // pin synchronisers
  reg [3:0] clkSync1;
  reg [3:0] clkSync2;
  reg gtsSync1;
  reg gtsSync2;
  reg [15:0] padSync1;
  reg [15:0] padSync2;
  reg [3:0] clkPrev_reg;

  wire [117:0] termOut;
  wire [15:0] mcSum;
  wire [3:0] clkLevel;
  wire [3:0] clkRise;
  wire [3:0] clkFall;
  wire [15:0] qVec;
  wire gtsActive;

  wire apbAccess = psel & penable;
  wire apbDone = apbAccess & pready;
  wire apbWrite = apbDone & pwrite;
  wire isTerm = paddr < `PLB_TERM_LIMIT;
  wire [6:0] termIdx = paddr[10:4];
  wire [1:0] termFld = paddr[3:2];
  wire isMcCfg = paddr[11:6] == `PLB_MCCFG_BASE >> 6;
  wire isPlaAlloc = paddr[11:6] == `PLB_PLAALLOC_BASE >> 6;
  wire [3:0] regIdx = paddr[5:2];
  wire aligned = paddr[1:0] == 2'h0;

  integer k;

  always @(posedge sysClk) begin
    clkSync1 <= {flexClockThree, flexClockTwo, flexClockOne, dedicatedSyncClock};
    clkSync2 <= clkSync1;
    gtsSync1 <= globalTristatePinN;
    gtsSync2 <= gtsSync1;
    padSync1 <= padIn;
    padSync2 <= padSync1;
  end

  // clock 0 always from its pin; flex clocks from pin or an equation
  assign clkLevel[0] = clkSync2[0];
  assign clkLevel[1] = clkCfg_reg[0] ? mcSum[clkCfg_reg[6:3]] : clkSync2[1];
  assign clkLevel[2] = clkCfg_reg[1] ? mcSum[clkCfg_reg[10:7]] : clkSync2[2];
  assign clkLevel[3] = clkCfg_reg[2] ? mcSum[clkCfg_reg[14:11]] : clkSync2[3];

  always @(posedge sysClk) begin
    if (sysRst) begin
      clkPrev_reg <= 4'h0;
    end else begin
      clkPrev_reg <= clkLevel;
    end
  end

  assign clkRise = clkLevel & ~clkPrev_reg;
  assign clkFall = ~clkLevel & clkPrev_reg;

  assign gtsActive = gtsEn_reg & ~gtsSync2;

  // all array terms share one evaluator
  genvar t;
  generate
    for (t = 0; t < `PLB_NUM_TERM; t = t + 1) begin : gTerm
      if (t >= `PLB_CT_BASE) begin : gCt
        plb_term uTerm (
          .inVec(iaIn),
          .trueMask(termTrue[t]),
          .compMask(termComp[t]),
          .sumMode(ctMode_reg[t - `PLB_CT_BASE]),
          .termOut(termOut[t])
        );
      end else begin : gPt
        plb_term uTerm (
          .inVec(iaIn),
          .trueMask(termTrue[t]),
          .compMask(termComp[t]),
          .sumMode(1'b0),
          .termOut(termOut[t])
        );
      end
    end
  endgenerate

  genvar m;
  generate
    for (m = 0; m < `PLB_NUM_MC; m = m + 1) begin : gMc
      // five own terms plus any pool terms, pool terms shared freely
      assign mcSum[m] = (|termOut[m*5+4 -: 5])
        | (|(termOut[111:80] & plaAlloc[m]));
      plb_macrocell uMc (
        .sysClk(sysClk),
        .sysRst(sysRst),
        .cfg(mcCfg[m]),
        .dataIn(mcSum[m]),
        .clkRise(clkRise),
        .clkFall(clkFall),
        .presetTerm(termOut[112]),
        .resetTerm(termOut[113]),
        .oeTerms(termOut[117:114]),
        .gtsActive(gtsActive),
        .qOut(qVec[m]),
        .oeOut(padOe[m])
      );
    end
  endgenerate

  assign padOut = qVec;
  assign fbMacro = qVec;

  // pin path feedback, after the buffer
  always @(posedge sysClk) begin
    if (sysRst) begin
      fbPin <= 16'h0000;
    end else begin
      fbPin <= padSync2;
    end
  end

  // term mask writes
  always @(posedge sysClk) begin
    if (sysRst) begin
      for (k = 0; k < `PLB_NUM_TERM; k = k + 1) begin
        termTrue[k] <= 36'h0;
        termComp[k] <= 36'h0;
      end
    end else if (apbWrite && isTerm && aligned) begin
      case (termFld)
        `PLB_TF_TRUE_LO: termTrue[termIdx][31:0] <= pwdata;
        `PLB_TF_TRUE_HI: termTrue[termIdx][35:32] <= pwdata[3:0];
        `PLB_TF_COMP_LO: termComp[termIdx][31:0] <= pwdata;
        default: termComp[termIdx][35:32] <= pwdata[3:0];
      endcase
    end
  end

  // macrocell and global config writes
  always @(posedge sysClk) begin
    if (sysRst) begin
      for (k = 0; k < `PLB_NUM_MC; k = k + 1) begin
        mcCfg[k] <= `PLB_MC_RESET;
        plaAlloc[k] <= 32'h0;
      end
      ctMode_reg <= 6'h00;
      clkCfg_reg <= `PLB_CLKCFG_RESET;
      gtsEn_reg <= 1'b0;
    end else if (apbWrite && aligned) begin
      if (isMcCfg) begin
        mcCfg[regIdx] <= pwdata[8:0];
      end
      if (isPlaAlloc) begin
        plaAlloc[regIdx] <= pwdata;
      end
      if (paddr == `PLB_ADDR_GCFG) begin
        gtsEn_reg <= pwdata[`PLB_GCFG_GTS_EN];
      end
      if (paddr == `PLB_ADDR_CTMODE) begin
        ctMode_reg <= pwdata[5:0];
      end
      if (paddr == `PLB_ADDR_CLKCFG) begin
        clkCfg_reg <= pwdata[14:0];
      end
    end
  end

  // read decode
  reg [31:0] rdata_next;
  reg rdErr_next;

  always @* begin
    rdata_next = 32'h0;
    rdErr_next = 1'b0;
    if (!aligned) begin
      rdErr_next = 1'b1;
    end else if (isTerm) begin
      case (termFld)
        `PLB_TF_TRUE_LO: rdata_next = termTrue[termIdx][31:0];
        `PLB_TF_TRUE_HI: rdata_next = {28'h0, termTrue[termIdx][35:32]};
        `PLB_TF_COMP_LO: rdata_next = termComp[termIdx][31:0];
        default: rdata_next = {28'h0, termComp[termIdx][35:32]};
      endcase
    end else if (isMcCfg) begin
      rdata_next = {23'h0, mcCfg[regIdx]};
    end else if (isPlaAlloc) begin
      rdata_next = plaAlloc[regIdx];
    end else begin
      case (paddr)
        `PLB_ADDR_GCFG: rdata_next = {31'h0, gtsEn_reg};
        `PLB_ADDR_CTMODE: rdata_next = {26'h0, ctMode_reg};
        `PLB_ADDR_CLKCFG: rdata_next = {17'h0, clkCfg_reg};
        `PLB_ADDR_STATUS: rdata_next = {padSync2, qVec};
        default: rdErr_next = 1'b1;
      endcase
    end
  end

  // one wait state: ready rises in the first access cycle's edge
  always @(posedge sysClk) begin
    if (sysRst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (apbAccess && !pready) begin
      pready <= 1'b1;
      pslverr <= rdErr_next;
      prdata <= pwrite ? 32'h0 : rdata_next;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule

// file: rtl/plb_map.vh
`ifndef PLB_MAP_VH
`define PLB_MAP_VH

// logic block sizes
`define PLB_NUM_IN 36
`define PLB_NUM_MC 16
`define PLB_PAL_PER_MC 5
`define PLB_NUM_PAL 80
`define PLB_NUM_PLA 32
`define PLB_NUM_CT 6
`define PLB_NUM_TERM 118
`define PLB_PLA_BASE 80
`define PLB_CT_BASE 112
`define PLB_NUM_CLK 4

// apb byte addresses
`define PLB_ADDR_W 12
`define PLB_TERM_LIMIT 12'h760
`define PLB_ADDR_GCFG 12'h800
`define PLB_ADDR_CTMODE 12'h804
`define PLB_ADDR_CLKCFG 12'h808
`define PLB_ADDR_STATUS 12'h80C
`define PLB_MCCFG_BASE 12'h840
`define PLB_PLAALLOC_BASE 12'h880

// term word fields, addr[3:2]
`define PLB_TF_TRUE_LO 2'h0
`define PLB_TF_TRUE_HI 2'h1
`define PLB_TF_COMP_LO 2'h2
`define PLB_TF_COMP_HI 2'h3

// macrocell config fields
`define PLB_MC_W 9
`define PLB_MC_TTYPE 0
`define PLB_MC_FALL 1
`define PLB_MC_CLK_LO 2
`define PLB_MC_CLK_HI 3
`define PLB_MC_PSEN 4
`define PLB_MC_RSEN 5
`define PLB_MC_OE_LO 6
`define PLB_MC_OE_HI 8
`define PLB_MC_RESET 9'h000

// output enable selections
`define PLB_OE_ALWAYS 3'h4
`define PLB_OE_NEVER 3'h5

// clock config: [2:0] internal select, then 4-bit macrocell index per flex clock
`define PLB_CLKCFG_W 15
`define PLB_CLKCFG_RESET 15'h0000
`define PLB_GCFG_GTS_EN 0

`endif

// file: rtl/plb_term.v
`timescale 1ns/1ps
// one array term: product of selected literals, or their sum
module plb_term (
  input wire [35:0] inVec,
  input wire [35:0] trueMask,
  input wire [35:0] compMask,
  input wire sumMode,
  output wire termOut
);
  wire [35:0] used = trueMask | compMask;
  wire [35:0] litHit = (inVec & trueMask) | (~inVec & compMask);
  wire [35:0] litFail = (~inVec & trueMask) | (inVec & compMask);
  // a term with no literals stays low
  wire prodOut = (|used) & ~(|litFail);
  assign termOut = sumMode ? (|litHit) : prodOut;
endmodule

// file: rtl/plb_macrocell.v
`timescale 1ns/1ps
`include "plb_map.vh"
module plb_macrocell (
  input wire sysClk,
  input wire sysRst,
  input wire [8:0] cfg,
  input wire dataIn,
  input wire [3:0] clkRise,
  input wire [3:0] clkFall,
  input wire presetTerm,
  input wire resetTerm,
  input wire [3:0] oeTerms,
  input wire gtsActive,
  output reg qOut,
  output reg oeOut
);
  wire [1:0] clkSel = cfg[`PLB_MC_CLK_HI:`PLB_MC_CLK_LO];
  wire [2:0] oeSel = cfg[`PLB_MC_OE_HI:`PLB_MC_OE_LO];
  wire edgeHit = cfg[`PLB_MC_FALL] ? clkFall[clkSel] : clkRise[clkSel];
  reg oe_next;

  always @(posedge sysClk) begin
    if (sysRst) begin
      qOut <= 1'b0;
    end else if (cfg[`PLB_MC_RSEN] && resetTerm) begin
      qOut <= 1'b0;
    end else if (cfg[`PLB_MC_PSEN] && presetTerm) begin
      qOut <= 1'b1;
    end else if (edgeHit) begin
      if (cfg[`PLB_MC_TTYPE]) begin
        qOut <= qOut ^ dataIn;
      end else begin
        qOut <= dataIn;
      end
    end
  end

  always @* begin
    case (oeSel)
      3'h0, 3'h1, 3'h2, 3'h3: oe_next = oeTerms[oeSel[1:0]];
      `PLB_OE_ALWAYS: oe_next = 1'b1;
      default: oe_next = 1'b0;
    endcase
    if (gtsActive) begin
      oe_next = 1'b0;
    end
  end

  always @(posedge sysClk) begin
    if (sysRst) begin
      oeOut <= 1'b0;
    end else begin
      oeOut <= oe_next;
    end
  end
endmodule

// file: sim/plb_chk_checker.sv
`timescale 1ns/1ps
module plb_chk (
  input wire sysClk,
  input wire sysRst,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [15:0] padOut,
  input wire [15:0] padOe,
  input wire [15:0] fbMacro
);
  default clocking cb @(posedge sysClk); endclocking
  default disable iff (sysRst);
  chk_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after wait state");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_ready_req: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  chk_idle_quiet: assert property (!psel |=> !pready)
    else $error("pready without select");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_err_pulse: assert property (pslverr |=> !pslverr)
    else $error("pslverr longer than one cycle");
  chk_fb_paths: assert property (fbMacro == padOut)
    else $error("macrocell feedback differs from output");
  chk_rst_clear: assert property (disable iff (1'b0)
    sysRst |=> fbMacro == 16'h0000 && padOe == 16'h0000)
    else $error("flip-flops not cleared by reset");
  cover property (pslverr);
  cover property ($rose(fbMacro[1]));
  cover property ($fell(padOe[0]));
endmodule
bind plb_logic_block plb_chk u_chk (.sysClk(sysClk), .sysRst(sysRst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .padOut(padOut),
  .padOe(padOe), .fbMacro(fbMacro));

// file: sim/plb_pins.sv
`timescale 1ns/1ps
module plb_pins (
  input wire sysClk,
  input wire [15:0] padOut,
  input wire [15:0] padOe,
  output wire [15:0] padIn,
  output reg clkPin
);
  reg [15:0] extDrive;
  initial begin
    clkPin = 1'b0;
    extDrive = 16'h0080;
  end
  // undriven buffers let the outside driver set the pin
  assign padIn = (padOe & padOut) | (~padOe & extDrive);
  // the dedicated clock is only ever made out here
  task clkTo(input v);
    begin
      clkPin <= v;
      repeat (8) @(posedge sysClk);
    end
  endtask
endmodule

// file: sim/plb_logic_block_tb.sv
`timescale 1ns/1ps
module plb_logic_block_tb;
  reg sysClk = 1'b0;
  reg sysRst = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000;
  reg [35:0] iaIn = 36'h000000000;
  reg globalTristatePinN = 1'b1;
  reg flexClockOne = 1'b0;
  reg flexClockTwo = 1'b0;
  reg flexClockThree = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, clkPin;
  wire [15:0] padIn, padOut, padOe, fbMacro, fbPin;
  reg [31:0] rdat;
  reg errBit;
  integer n_mismatch = 0;
  integer tests_run = 0;
  always #2.5 sysClk = ~sysClk;
  plb_logic_block u_dut (.sysClk(sysClk), .sysRst(sysRst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .iaIn(iaIn),
    .dedicatedSyncClock(clkPin), .flexClockOne(flexClockOne), .flexClockTwo(flexClockTwo),
    .flexClockThree(flexClockThree), .globalTristatePinN(globalTristatePinN),
    .padIn(padIn), .padOut(padOut), .padOe(padOe), .fbMacro(fbMacro), .fbPin(fbPin));
  plb_pins u_pin (.sysClk(sysClk), .padOut(padOut), .padOe(padOe), .padIn(padIn),
    .clkPin(clkPin));
  task acc(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge sysClk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sysClk);
      penable <= 1'b1;
      do @(posedge sysClk); while (pready !== 1'b1);
      rdat = prdata;
      errBit = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        $display("ERROR t=%0t got %h exp %h", $time, g, e);
        n_mismatch = n_mismatch + 1;
      end
    end
  endtask
  task results;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #20000;
    n_mismatch = n_mismatch + 1;
    results;
  end
  initial begin
    repeat (4) @(posedge sysClk);
    sysRst <= 1'b0;
    @(posedge sysClk);
    chk({padOe, fbMacro}, 32'h00000000);
    // cells 0..4 on input 0, cell 5 preset by input 1, cell 6 buffer off
    acc(1'b1, 12'h000, 32'h00000001);
    acc(1'b1, 12'h050, 32'h00000001);
    acc(1'b1, 12'h0A0, 32'h00000001);
    acc(1'b1, 12'h500, 32'h00000001);
    acc(1'b1, 12'h700, 32'h00000002);
    acc(1'b1, 12'h804, 32'h00000001);
    acc(1'b1, 12'h840, 32'h00000100);
    acc(1'b1, 12'h844, 32'h00000102);
    acc(1'b1, 12'h848, 32'h00000101);
    acc(1'b1, 12'h84C, 32'h00000100);
    acc(1'b1, 12'h850, 32'h00000100);
    acc(1'b1, 12'h854, 32'h00000110);
    acc(1'b1, 12'h858, 32'h00000140);
    acc(1'b1, 12'h88C, 32'h00000001);
    acc(1'b1, 12'h890, 32'h00000001);
    iaIn <= 36'h000000001;
    u_pin.clkTo(1'b1);
    chk({16'h0000, fbMacro}, 32'h0000001D);
    u_pin.clkTo(1'b0);
    chk({16'h0000, fbMacro}, 32'h0000001F);
    u_pin.clkTo(1'b1);
    chk({16'h0000, fbMacro}, 32'h0000001B);
    iaIn <= 36'h000000000;
    u_pin.clkTo(1'b0);
    chk({16'h0000, fbMacro}, 32'h00000019);
    u_pin.clkTo(1'b1);
    chk({16'h0000, fbMacro}, 32'h00000000);
    iaIn <= 36'h000000002;
    repeat (4) @(posedge sysClk);
    chk({16'h0000, fbMacro}, 32'h00000020);
    chk({16'h0000, padOe}, 32'h0000003F);
    acc(1'b1, 12'h800, 32'h00000001);
    globalTristatePinN <= 1'b0;
    repeat (6) @(posedge sysClk);
    chk({16'h0000, padOe}, 32'h00000000);
    globalTristatePinN <= 1'b1;
    repeat (10) @(posedge sysClk);
    chk({16'h0000, padOe}, 32'h0000003F);
    chk({16'h0000, fbPin}, 32'h000000A0);
    acc(1'b0, 12'h80C, 32'h00000000);
    chk(rdat, 32'h00A00020);
    acc(1'b1, 12'h900, 32'hFFFFFFFF);
    chk({31'h00000000, errBit}, 32'h00000001);
    acc(1'b0, 12'h900, 32'h00000000);
    chk({errBit, rdat[30:0]}, 32'h80000000);
    // cell 7 on input 0, clocked by the first flex clock from its pin
    acc(1'b1, 12'h230, 32'h00000001);
    acc(1'b1, 12'h85C, 32'h00000104);
    iaIn <= 36'h000000001;
    repeat (8) @(posedge sysClk);
    chk({16'h0000, fbMacro}, 32'h00000020);
    flexClockOne <= 1'b1;
    repeat (8) @(posedge sysClk);
    chk({16'h0000, fbMacro}, 32'h000000A0);
    results;
  end
endmodule
